// [design/twisted_pair_autoneg_arbiter_regs.vh]
// How it works
// - Transmitted burst ability field comes from the advertisement register.
// - A consistent received partner code word is stored in the partner register.
// - Common abilities resolve by fixed priority, full duplex 100TX first.
// - 100Base-T4 is never selected; resolution falls to the next common one.
// - Bursts replace link pulses while negotiating; both ends must enable it.
// - Success sets the complete bit in status and consolidated status.
// - After completion the negotiated technology is enabled.
// - After completion every other technology is disabled.
// - With no burst reply the block falls back to parallel detection.
// - Parallel detection clears the partner-negotiation-capable bit.
// - Parallel detection sets partner bit 5 for 10T or bit 7 for 100TX.
// - Parallel detection sets complete, then enables only that technology.
// - Normal link pulses mean a 10Base-T only partner.
// - Scrambled 100M idles mean a non-negotiating 100Base-TX partner.
// - Burst replies set the partner-negotiation-capable bit.
// - No receive signal sets the no-signal consolidated status bit.
// - Several technology indications enable nothing and set the fault bit.
// - Reset returns the arbiter to idle and clears its status.
// - Restart bit or link failure restarts; the restart bit self-clears.
`ifndef TWISTED_PAIR_AUTONEG_ARBITER_REGS_VH
`define TWISTED_PAIR_AUTONEG_ARBITER_REGS_VH
`define IDX_CTRL 6'h00
`define IDX_STAT 6'h01
`define IDX_ADV 6'h04
`define IDX_LP 6'h05
`define IDX_EXP 6'h06
`define IDX_QUICK 6'h11
`define CTRL_RESTART 9
`define CTRL_AN_EN 12
`define STAT_AN_ABLE 3
`define STAT_AN_DONE 5
`define AB_10HD 5
`define AB_10FD 6
`define AB_TXHD 7
`define AB_TXFD 8
`define AB_T4 9
`define AB_ACK 14
`define EXP_LP_ABLE 0
`define EXP_PD_FAULT 4
`define Q_RATE 15
`define Q_DUPLEX 14
`define Q_DONE 4
`define Q_NOSIG 3
`define Q_LINK 0
`define ADV_RESET 16'h01E1
`define CTRL_RESET 16'h1000
`define MATCH_WORDS 3
`define ACK_WORDS 3
`define PD_SETTLE_MS 750
`define CLK_KHZ 125000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [design/twisted_pair_autoneg_arbiter.v]
`timescale 1ns/1ns
`default_nettype none
`include "twisted_pair_autoneg_arbiter_regs.vh"
module twisted_pair_autoneg_arbiter #(
   parameter ADDR_W = 8,
   parameter PD_SETTLE = `PD_SETTLE_MS * `CLK_KHZ
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // AXI4-Lite write
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Receive indications from the pulse front end
   input wire [15:0] rx_flp_word,
   input wire rx_flp_valid,
   input wire rx_nlp,
   input wire rx_idle100,
   input wire rx_signal,
   input wire link_fail,
   // Transmit and technology control
   output reg [15:0] tx_flp_word,
   output reg tx_flp_en,
   output reg tx_nlp_en,
   output reg en_100tx,
   output reg en_10t,
   output reg full_duplex
);

localparam S_IDLE = 3'h0;
localparam S_ABIL = 3'h1;
localparam S_ACK = 3'h2;
localparam S_PD = 3'h3;
localparam S_DONE = 3'h4;

localparam M_NONE = 3'h0;
localparam M_10HD = 3'h1;
localparam M_10FD = 3'h2;
localparam M_TXHD = 3'h3;
localparam M_TXFD = 3'h4;

// Control word as it stands after reset
localparam [15:0] CTRL_INIT = `CTRL_RESET;

// Highest common technology first
// T4 bit never tested: there is no T4 datapath behind it
function [2:0] resolve;
   input [15:0] c;
   begin
      if (c[`AB_TXFD])
         resolve = M_TXFD;
      else if (c[`AB_TXHD])
         resolve = M_TXHD;
      else if (c[`AB_10FD])
         resolve = M_10FD;
      else if (c[`AB_10HD])
         resolve = M_10HD;
      else
         resolve = M_NONE;
   end
endfunction

// Byte-lane merge of the low half-word
function [15:0] merge;
   input [15:0] old;
   input [31:0] nw;
   input [3:0] strb;
   begin
      merge[7:0] = strb[0] ? nw[7:0] : old[7:0];
      merge[15:8] = strb[1] ? nw[15:8] : old[15:8];
   end
endfunction

reg [ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
reg an_en;
reg restart_req;
reg [15:0] adv;
reg [15:0] lp;
reg lp_able;
reg pd_fault;
reg an_done;
reg [2:0] mode;
reg [2:0] state;
reg [15:0] last_word;
reg [1:0] match_cnt;
reg [1:0] ack_cnt;
reg [31:0] pd_timer;
reg no_signal;
reg [31:0] rd_word;
reg [15:0] next_tx_word;

wire [5:0] wr_idx = aw_addr[7:2];
wire [5:0] rd_idx = s_axi_araddr[7:2];
wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
wire rd_go = s_axi_arvalid && s_axi_arready;
wire wr_ctrl = wr_go && wr_idx == `IDX_CTRL;
wire wr_adv = wr_go && wr_idx == `IDX_ADV;
wire [15:0] ctrl_new = merge({3'h0, an_en, 12'h000}, w_data, w_strb);
wire restart = restart_req || link_fail || !an_en;
wire fault_clr = rd_go && rd_idx == `IDX_EXP;
wire [15:0] common = adv & lp;

function wr_ok;
   input [5:0] idx;
   begin
      wr_ok = idx == `IDX_CTRL || idx == `IDX_STAT || idx == `IDX_ADV ||
         idx == `IDX_LP || idx == `IDX_EXP || idx == `IDX_QUICK;
   end
endfunction

// Write channel: address and data may arrive in either order
always @(posedge clock or posedge rst) begin
   if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
   end else begin
      if (s_axi_awvalid && s_axi_awready) begin
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
   end
end

// Software-writable control and advertisement
always @(posedge clock or posedge rst) begin
   if (rst) begin
      an_en <= CTRL_INIT[`CTRL_AN_EN];
      restart_req <= 1'b0;
      adv <= `ADV_RESET;
   end else begin
      restart_req <= wr_ctrl && ctrl_new[`CTRL_RESTART];
      if (wr_ctrl)
         an_en <= ctrl_new[`CTRL_AN_EN];
      if (wr_adv)
         adv <= merge(adv, w_data, w_strb);
   end
end

always @* begin
   rd_word = 32'h00000000;
   case (rd_idx)
      `IDX_CTRL: rd_word[`CTRL_AN_EN] = an_en;
      `IDX_STAT: begin
         rd_word[`STAT_AN_ABLE] = 1'b1;
         rd_word[`STAT_AN_DONE] = an_done;
      end
      `IDX_ADV: rd_word[15:0] = adv;
      `IDX_LP: rd_word[15:0] = lp;
      `IDX_EXP: begin
         rd_word[`EXP_LP_ABLE] = lp_able;
         rd_word[`EXP_PD_FAULT] = pd_fault;
      end
      `IDX_QUICK: begin
         rd_word[`Q_RATE] = mode == M_TXFD || mode == M_TXHD;
         rd_word[`Q_DUPLEX] = mode == M_TXFD || mode == M_10FD;
         rd_word[`Q_DONE] = an_done;
         rd_word[`Q_NOSIG] = no_signal;
         rd_word[`Q_LINK] = mode != M_NONE;
      end
      default: rd_word = 32'h00000000;
   endcase
end

// Ack bit rides in the advertised word only while acknowledging
always @* begin
   next_tx_word = adv;
   next_tx_word[`AB_ACK] = state == S_ACK;
end

// Read channel
always @(posedge clock or posedge rst) begin
   if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
   end else begin
      if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= wr_ok(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
end

// Arbitration state machine
always @(posedge clock or posedge rst) begin
   if (rst) begin
      state <= S_IDLE;
      lp <= 16'h0000;
      lp_able <= 1'b0;
      pd_fault <= 1'b0;
      an_done <= 1'b0;
      mode <= M_NONE;
      last_word <= 16'h0000;
      match_cnt <= 2'h0;
      ack_cnt <= 2'h0;
      pd_timer <= 32'h00000000;
   end else begin
      // Read clears the fault, but a new fault this cycle wins
      if (fault_clr)
         pd_fault <= 1'b0;
      if (restart) begin
         state <= S_IDLE;
         an_done <= 1'b0;
         mode <= M_NONE;
      end else begin
         case (state)
            S_IDLE: begin
               match_cnt <= 2'h0;
               ack_cnt <= 2'h0;
               pd_timer <= 32'h00000000;
               state <= S_ABIL;
            end
            S_ABIL: begin
               if (rx_flp_valid) begin
                  lp_able <= 1'b1;
                  last_word <= rx_flp_word;
                  // Three identical words before trusting the partner
                  if (rx_flp_word != last_word || match_cnt == 2'h0) begin
                     match_cnt <= 2'h1;
                  end else if (match_cnt == `MATCH_WORDS - 1) begin
                     lp <= rx_flp_word;
                     ack_cnt <= 2'h0;
                     state <= S_ACK;
                  end else begin
                     match_cnt <= match_cnt + 2'h1;
                  end
               end else if (rx_nlp || rx_idle100) begin
                  pd_timer <= 32'h00000000;
                  state <= S_PD;
               end
            end
            S_ACK: begin
               // No timeout: a partner that stops acking holds us here until restart
               if (rx_flp_valid && rx_flp_word[`AB_ACK]) begin
                  if (ack_cnt == `ACK_WORDS - 1) begin
                     mode <= resolve(common);
                     an_done <= 1'b1;
                     state <= S_DONE;
                  end else begin
                     ack_cnt <= ack_cnt + 2'h1;
                  end
               end
            end
            S_PD: begin
               // Link pulses or 100M idles must persist, in any mix, for the whole settle time
               pd_timer <= pd_timer + 32'h00000001;
               if (rx_flp_valid || !(rx_nlp || rx_idle100)) begin
                  state <= S_ABIL;
               end else if (pd_timer == PD_SETTLE - 1) begin
                  if (rx_nlp && rx_idle100) begin
                     pd_fault <= 1'b1;
                     mode <= M_NONE;
                     state <= S_ABIL;
                  end else begin
                     lp_able <= 1'b0;
                     an_done <= 1'b1;
                     state <= S_DONE;
                     if (rx_nlp) begin
                        lp <= 16'h0000 | (16'h0001 << `AB_10HD);
                        mode <= M_10HD;
                     end else begin
                        lp <= 16'h0000 | (16'h0001 << `AB_TXHD);
                        mode <= M_TXHD;
                     end
                  end
               end
            end
            S_DONE: state <= S_DONE;
            default: state <= S_IDLE;
         endcase
      end
   end
end

// Registered line-side outputs
always @(posedge clock or posedge rst) begin
   if (rst) begin
      tx_flp_word <= 16'h0000;
      tx_flp_en <= 1'b0;
      tx_nlp_en <= 1'b0;
      en_100tx <= 1'b0;
      en_10t <= 1'b0;
      full_duplex <= 1'b0;
      no_signal <= 1'b0;
   end else begin
      tx_flp_word <= next_tx_word;
      tx_flp_en <= an_en && state != S_DONE && state != S_IDLE;
      tx_nlp_en <= !an_en || (state == S_DONE && !en_100tx);
      // Only the selected technology draws power
      en_100tx <= an_done && (mode == M_TXFD || mode == M_TXHD);
      en_10t <= an_done && (mode == M_10FD || mode == M_10HD);
      full_duplex <= an_done && (mode == M_TXFD || mode == M_10FD);
      no_signal <= !rx_signal;
   end
end

endmodule // twisted_pair_autoneg_arbiter
`default_nettype wire

// [verification/arbiter_checker_props.sv]
`timescale 1ns/1ns
`default_nettype none
module arbiter_props (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Link side
   input wire logic link_fail,
   input wire logic tx_flp_en,
   input wire logic en_100tx,
   input wire logic en_10t,
   input wire logic full_duplex
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   write_answer_a: assert property (wr_take |=> ##1 s_axi_bvalid)
      else $error("write response missing");
   read_answer_a: assert property (rd_take |=> s_axi_rvalid)
      else $error("read response missing");
   write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   one_tech_a: assert property (!(en_100tx && en_10t))
      else $error("two technologies enabled");
   duplex_tech_a: assert property (full_duplex |-> en_100tx || en_10t)
      else $error("duplex without technology");
   burst_start_a: assert property ($fell(rst) && !link_fail |-> ##[1:3] tx_flp_en)
      else $error("bursts not started");
   reset_idle_a: assert property (disable iff (1'b0) rst |-> !en_100tx && !en_10t && !tx_flp_en)
      else $error("outputs active in reset");
   fail_restart_a: assert property (link_fail [*3] |-> !en_100tx && !en_10t)
      else $error("technology kept on link failure");
endmodule // arbiter_props
bind twisted_pair_autoneg_arbiter arbiter_props u_arbiter_props (.*);
`default_nettype wire

// [verification/link_partner_model.sv]
`timescale 1ns/1ns
`default_nettype none
module link_partner_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bench control: 0 silent, 1 bursts, 2 link pulses, 3 idles, 4 both
   input wire logic [2:0] mode,
   input wire logic [15:0] ability,
   // From the device
   input wire logic tx_flp_en,
   input wire logic [15:0] tx_flp_word,
   // To the device
   output logic [15:0] rx_flp_word,
   output logic rx_flp_valid,
   output logic rx_nlp,
   output logic rx_idle100,
   output logic rx_signal
);
   logic [2:0] gap;
   logic acked;
   // Abilities and the ack bit are sent; the far end resolves with the same order
   assign rx_nlp = mode == 3'h2 || mode == 3'h4;
   assign rx_idle100 = mode == 3'h3 || mode == 3'h4;
   assign rx_signal = mode != 3'h0;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gap <= 3'h0;
         acked <= 1'b0;
         rx_flp_valid <= 1'b0;
         rx_flp_word <= 16'h0000;
      end else begin
         gap <= gap + 3'h1;
         // Acknowledge only once the device acknowledges
         acked <= tx_flp_en && (acked || tx_flp_word[14]);
         rx_flp_valid <= mode == 3'h1 && gap == 3'h7;
         // Word line toggles between bursts so stale data never looks valid
         rx_flp_word <= (mode == 3'h1 && gap == 3'h7) ?
            {ability[15], acked, ability[13:0]} : ~rx_flp_word;
      end
   end
endmodule // link_partner_model
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clock = 1'b0;
   logic rst = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, link_fail = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [15:0] rx_flp_word, tx_flp_word, ability = 16'h0000;
   logic rx_flp_valid, rx_nlp, rx_idle100, rx_signal, tx_flp_en, tx_nlp_en;
   logic en_100tx, en_10t, full_duplex;
   logic [2:0] mode = 3'h0;
   logic [15:0] adv_tab [5] = '{16'h01E1, 16'h00A1, 16'h03E1, 16'h0021, 16'h0081};
   logic [15:0] lp_tab [5] = '{16'h01E1, 16'h0181, 16'h0261, 16'h0021, 16'h0021};
   logic [2:0] tech_tab [5] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h0};
   int num_errors = 0, num_checks = 0;
   always #4 clock = ~clock;
   twisted_pair_autoneg_arbiter #(.PD_SETTLE(20)) u_twisted_pair_autoneg_arbiter (.*);
   link_partner_model u_link_partner_model (.*);
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Ready lines are looked at mid-cycle, where they hold what the next edge samples
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      fork
         begin
            do @(negedge clock); while (!s_axi_awready);
            @(posedge clock);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(negedge clock); while (!s_axi_wready);
            @(posedge clock);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(negedge clock); while (!s_axi_bvalid);
      @(posedge clock);
      s_axi_bready <= 1'b1;
      // Answer taken at the handshake edge, before that edge's updates land
      @(posedge clock);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge clock); while (!s_axi_arready);
      @(posedge clock);
      s_axi_arvalid <= 1'b0;
      do @(negedge clock); while (!s_axi_rvalid);
      @(posedge clock);
      s_axi_rready <= 1'b1;
      @(posedge clock);
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic run(input logic [2:0] m, input logic [15:0] ab, input logic [15:0] adv);
      mode <= m;
      ability <= ab;
      wr(8'h10, {16'h0000, adv});
      wr(8'h00, 32'h00001200);
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      do begin
         rd(8'h04);
         n++;
      end while (rd_data[5] !== 1'b1 && n < 300);
      check("complete", rd_data[5], 1'b1);
      repeat (2) @(posedge clock);
   endtask
   initial begin
      // Reset edge at time zero so outputs are known at the first clock
      rst <= 1'b1;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rd(8'h00); check("ctrl", rd_data, 32'h00001000);
      rd(8'h10); check("adv", rd_data, 32'h000001E1);
      rd(8'h44); check("no signal", rd_data[3], 1'b1);
      rd(8'h08); check("unmapped read", resp, 2'h2);
      wr(8'h08, 32'h0); check("unmapped write", resp, 2'h2);
      for (int i = 0; i < 5; i++) begin
         run(3'h1, lp_tab[i], adv_tab[i]);
         wait_done;
         check("tech", {en_100tx, en_10t, full_duplex}, tech_tab[i]);
         check("burst word", tx_flp_word, adv_tab[i]);
         check("pulses", {tx_flp_en, tx_nlp_en}, {1'b0, !tech_tab[i][2]});
         rd(8'h14); check("partner", rd_data, lp_tab[i]);
         rd(8'h18); check("capable", rd_data[0], 1'b1);
         rd(8'h44); check("done mirror", rd_data[4], 1'b1);
         check("rate duplex", {rd_data[15], rd_data[14]}, {tech_tab[i][2], tech_tab[i][0]});
      end
      rd(8'h00); check("restart clear", rd_data, 32'h00001000);
      wr(8'h00, 32'h0);
      repeat (2) @(posedge clock);
      check("negotiation off", {tx_flp_en, tx_nlp_en, en_100tx, en_10t}, 4'h4);
      for (int i = 0; i < 2; i++) begin
         run(i ? 3'h3 : 3'h2, 16'h0000, 16'h01E1);
         wait_done;
         check("pd tech", {en_100tx, en_10t, full_duplex}, i ? 3'h4 : 3'h2);
         rd(8'h14); check("pd partner", rd_data[7:5], i ? 3'h4 : 3'h1);
         rd(8'h18); check("pd capable", rd_data[0], 1'b0);
      end
      run(3'h4, 16'h0000, 16'h01E1);
      repeat (60) @(posedge clock);
      check("fault tech", {en_100tx, en_10t}, 2'h0);
      rd(8'h18); check("pd fault", rd_data[4], 1'b1);
      run(3'h1, 16'h01E1, 16'h01E1);
      wait_done;
      link_fail <= 1'b1;
      repeat (4) @(posedge clock);
      check("fail tech", {en_100tx, en_10t}, 2'h0);
      rd(8'h04); check("fail restart", rd_data[5], 1'b0);
      link_fail <= 1'b0;
      wait_done;
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd(8'h04); check("reset done", rd_data[5], 1'b0);
      close_out;
   end
   initial begin
      repeat (60000) @(posedge clock);
      num_errors++;
      close_out;
   end
endmodule // tb_top
`default_nettype wire
